//--- src/uart_pins_pkg.sv
// Package with register offsets, field positions, reset values and timing counts of the UART pin block.
package uart_pins_pkg;

   // -------------------------------------------------------------------
   // Register offsets on the three select lines
   // -------------------------------------------------------------------
   localparam logic [2:0] IRQ_ENABLE_OFS   = 3'h1;
   localparam logic [2:0] ENH_FEATURE_OFS  = 3'h2;
   localparam logic [2:0] MODEM_CTRL_OFS   = 3'h4;
   localparam logic [2:0] LINE_STATUS_OFS  = 3'h5;
   localparam logic [2:0] MODEM_STATUS_OFS = 3'h6;
   localparam logic [2:0] SCRATCH_OFS      = 3'h7;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int MCR_DTR_BIT       = 0;
   localparam int MCR_RTS_BIT       = 1;
   localparam int MCR_IRQ_OE_BIT    = 3;
   localparam int MCR_IR_MODE_BIT   = 6;
   localparam int EFR_AUTO_RTS_BIT  = 6;
   localparam int EFR_AUTO_CTS_BIT  = 7;
   localparam int IER_RTS_IRQ_BIT   = 6;
   localparam int IER_CTS_IRQ_BIT   = 7;
   localparam int MSR_CTS_BIT       = 4;
   localparam int LSR_RX_ACTIVE_BIT = 0;
   localparam int LSR_TX_STOP_BIT   = 1;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [7:0] BUS_RESET     = 8'h00;
   // Order: read_n, write_n, cs_n, isolate, rx, cts_n, dsr_n, cd_n, ri_n, addr[2:0].
   localparam logic [11:0] PIN_RESET    = 12'hEF8;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int RST_MIN_NS    = 40;
   localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- src/pin_sync.sv
// Two-flop synchroniser for a group of pins arriving from outside the clock domain.
module pin_sync
   import uart_pins_pkg::*;
#(
   parameter int           W         = 8,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;

   // A group of zero pins has nothing to synchronise, so it is refused at elaboration.
   if (W < 1)
   begin : g_width_check
      $error("pin_sync needs at least one bit");
   end

   // Only the second stage may be read by any logic.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end
      else
      begin
         meta_q <= pin_i;
         sync_o <= meta_q;
      end
   end

endmodule

//--- src/uart_pins.sv
// Host bus, interrupt pin and serial/modem pin logic of a single-channel UART.
// Behaviour
// - Read strobe falling edge starts a read and drives the selected register byte.
// - Write starts at strobe fall; rising edge latches bus byte into selected register.
// - Strobes are honoured only while chip select is low.
// - Interrupt output is active high and three-state.
// - Interrupt pin drives when modem control bit 3 is 1, else floats.
// - Modem control bit 6 clear: transmit idles high, also during reset.
// - Modem control bit 6 set: infrared path, transmit rests low.
// - Receive idles high in standard mode, low in infrared mode.
// - Clear-to-send feeds auto transmit stop, status bit 4, interrupt enable bit 7.
// - Request-to-send and terminal-ready outputs double as software outputs.
// - Set-ready, carrier and ring inputs readable as status or general inputs.
// - Power-save input isolates the host bus and ignores its activity.
// - Reset pulse of at least 40 ns returns registers and outputs to defaults.
// - During reset transmit is held high and receive is ignored.
// - Three select lines pick the register for each bus access.
// - Eight-bit data bus is driven by the device only during reads.
// - Bus cycles are timed only by chip select and strobes; the block samples both on the system clock through two flops.
module uart_pins
   import uart_pins_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       chip_sel_n_i,
   input  wire logic       read_strobe_n_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic [2:0] register_select_lines_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o,
   output logic            data_oe_o,
   input  wire logic       bus_isolate_in_i,
   output logic            irq_o,
   output logic            irq_oe_o,
   output logic            tx_o,
   input  wire logic       rx_i,
   output logic            rx_active_o,
   output logic            rts_n_o,
   output logic            dtr_n_o,
   output logic            tx_stop_o,
   input  wire logic       cts_n_i,
   input  wire logic       dsr_n_i,
   input  wire logic       cd_n_i,
   input  wire logic       ri_n_i
);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic [11:0] pins_s;
   logic [7:0]  data_s;

   // The strobes are asynchronous to the system clock, so every pin is brought in through two flops.
   pin_sync #(.W(12), .RESET_VAL(PIN_RESET)) u_ctl_sync
   (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({read_strobe_n_i, write_strobe_n_i, chip_sel_n_i, bus_isolate_in_i, rx_i,
                   cts_n_i, dsr_n_i, cd_n_i, ri_n_i, register_select_lines_i}),
      .sync_o    (pins_s)
   );

   pin_sync #(.W(8), .RESET_VAL(BUS_RESET)) u_data_sync
   (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (data_i),
      .sync_o    (data_s)
   );

   wire       rd_n_s  = pins_s[11];
   wire       wr_n_s  = pins_s[10];
   wire       cs_n_s  = pins_s[9];
   wire       iso_s   = pins_s[8];
   wire       rx_s    = pins_s[7];
   // Asserted-high modem lines: bit 0 clear-to-send, 1 set-ready, 2 carrier, 3 ring.
   wire [3:0] modem_s = ~{pins_s[3], pins_s[4], pins_s[5], pins_s[6]};
   wire [2:0] addr_s  = pins_s[2:0];

   // -------------------------------------------------------------------
   // Strobe edges and bus cycle tracking
   // -------------------------------------------------------------------
   logic rd_n_q;
   logic wr_n_q;
   logic rd_act_q;
   logic wr_act_q;

   wire bus_sel    = !cs_n_s && !iso_s;
   wire rd_fall    = rd_n_q && !rd_n_s;
   wire rd_rise    = !rd_n_q && rd_n_s;
   wire wr_fall    = wr_n_q && !wr_n_s;
   wire wr_rise    = !wr_n_q && wr_n_s;
   wire rd_start   = rd_fall && bus_sel;
   wire wr_commit  = wr_rise && wr_act_q && bus_sel;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rd_n_q   <= 1'b1;
         wr_n_q   <= 1'b1;
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end
      else
      begin
         rd_n_q   <= rd_n_s;
         wr_n_q   <= wr_n_s;
         rd_act_q <= rd_start || (rd_act_q && !rd_rise && bus_sel);
         wr_act_q <= (wr_fall && bus_sel) || (wr_act_q && !wr_rise && bus_sel);
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic [7:0] ier_q;
   logic [7:0] efr_q;
   logic [7:0] mcr_q;
   logic [7:0] spr_q;
   logic [3:0] modem_q;
   logic [3:0] delta_q;
   logic [7:0] rd_data_q;

   wire wr_ier = wr_commit && (addr_s == IRQ_ENABLE_OFS);
   wire wr_efr = wr_commit && (addr_s == ENH_FEATURE_OFS);
   wire wr_mcr = wr_commit && (addr_s == MODEM_CTRL_OFS);
   wire wr_spr = wr_commit && (addr_s == SCRATCH_OFS);
   wire rd_msr = rd_start && (addr_s == MODEM_STATUS_OFS);

   // Status nibble order is cts, dsr, cd, ri in bits 4..7; delta bits 0..3 in the same order.
   wire [3:0] modem_chg = modem_s ^ modem_q;
   // A change seen in the cycle of the clearing read still sets its delta bit.
   wire [3:0] delta_d   = modem_chg | (rd_msr ? 4'h0 : delta_q);
   wire [7:0] msr_val   = {modem_q, delta_q};

   wire ir_mode   = mcr_q[MCR_IR_MODE_BIT];
   wire rx_idle   = ir_mode ? 1'b0 : 1'b1;
   wire rx_busy   = rx_s != rx_idle;
   wire tx_stop   = efr_q[EFR_AUTO_CTS_BIT] && !modem_q[0];
   wire [7:0] lsr_val = {6'h00, tx_stop, rx_busy};

   wire [7:0] rd_mux =
      (addr_s == IRQ_ENABLE_OFS)   ? ier_q   :
      (addr_s == ENH_FEATURE_OFS)  ? efr_q   :
      (addr_s == MODEM_CTRL_OFS)   ? mcr_q   :
      (addr_s == LINE_STATUS_OFS)  ? lsr_val :
      (addr_s == MODEM_STATUS_OFS) ? msr_val :
      (addr_s == SCRATCH_OFS)      ? spr_q   : 8'h00;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ier_q     <= REG_RESET;
         efr_q     <= REG_RESET;
         mcr_q     <= REG_RESET;
         spr_q     <= REG_RESET;
         modem_q   <= 4'h0;
         delta_q   <= 4'h0;
         rd_data_q <= REG_RESET;
      end
      else
      begin
         if (wr_ier) ier_q <= data_s;
         if (wr_efr) efr_q <= data_s;
         if (wr_mcr) mcr_q <= data_s;
         if (wr_spr) spr_q <= data_s;
         modem_q <= modem_s;
         delta_q <= delta_d;
         if (rd_start) rd_data_q <= rd_mux;
      end
   end

   // -------------------------------------------------------------------
   // Pin outputs
   // -------------------------------------------------------------------
   logic tx_q;
   logic rts_n_q;
   logic dtr_n_q;
   logic irq_q;
   logic rx_active_q;
   logic tx_stop_q;

   // Modem deltas raise the interrupt; clear-to-send has its own enable as well.
   wire irq_d = |(delta_q & ier_q[3:0]) || (ier_q[IER_CTS_IRQ_BIT] && delta_q[0]);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tx_q        <= 1'b1;
         rts_n_q     <= 1'b1;
         dtr_n_q     <= 1'b1;
         irq_q       <= 1'b0;
         rx_active_q <= 1'b0;
         tx_stop_q   <= 1'b0;
      end
      else
      begin
         tx_q        <= !ir_mode;
         rts_n_q     <= !mcr_q[MCR_RTS_BIT];
         dtr_n_q     <= !mcr_q[MCR_DTR_BIT];
         irq_q       <= irq_d;
         rx_active_q <= rx_busy;
         tx_stop_q   <= tx_stop;
      end
   end

   // No transmitter is attached here, so the line only ever shows its idle level.
   assign tx_o        = tx_q;
   assign rts_n_o     = rts_n_q;
   assign dtr_n_o     = dtr_n_q;
   assign irq_o       = irq_q;
   assign irq_oe_o    = mcr_q[MCR_IRQ_OE_BIT];
   assign rx_active_o = rx_active_q;
   assign tx_stop_o   = tx_stop_q;
   assign data_o      = rd_data_q;
   assign data_oe_o   = rd_act_q && !iso_s;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_read_drive:  assert property (rd_start |=> data_oe_o until_with rd_rise)
      else $error("read did not drive bus");
   a_read_value:  assert property (rd_start && addr_s == SCRATCH_OFS |=> data_o == $past(spr_q))
      else $error("read returned wrong byte");
   a_write_latch: assert property (wr_commit && addr_s == SCRATCH_OFS |=> spr_q == $past(data_s))
      else $error("write not latched");
   a_deselect_ignored: assert property (cs_n_s |=> $stable(mcr_q) && !$rose(rd_act_q))
      else $error("deselected strobe acted");
   a_irq_float:   assert property (wr_mcr && !data_s[MCR_IRQ_OE_BIT] |=> !irq_oe_o)
      else $error("interrupt pin not floated");
   a_tx_std_idle: assert property (wr_mcr && !data_s[MCR_IR_MODE_BIT] |=> ##1 tx_o)
      else $error("standard idle not high");
   a_tx_ir_idle:  assert property (wr_mcr && data_s[MCR_IR_MODE_BIT] |=> ##1 !tx_o)
      else $error("infrared idle not low");
   a_bus_isolate: assert property (iso_s |-> !data_oe_o ##1 !$rose(wr_act_q))
      else $error("bus active while isolated");
   a_rts_follow:  assert property (wr_mcr |=> ##1 rts_n_o == !$past(data_s[MCR_RTS_BIT], 2))
      else $error("request-to-send mismatch");
   a_cts_delta:   assert property ($changed(modem_s[0]) |=> delta_q[0] && msr_val[MSR_CTS_BIT] == $past(modem_s[0]))
      else $error("clear-to-send not reported");
   a_read_once:   assert property (rd_msr && !(|modem_chg) |=> delta_q == 4'h0)
      else $error("status read did not clear deltas");

   c_read:    cover property (rd_start ##[1:20] rd_rise);
   c_write:   cover property (wr_commit && addr_s == MODEM_CTRL_OFS);
   c_irq:     cover property (irq_o && irq_oe_o);
   c_isolate: cover property (iso_s && !rd_n_s && !cs_n_s);

endmodule

//--- tb/host_bus_model.sv
// Host processor model that drives the asynchronous byte bus of the UART pin block.
module host_bus_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] dev_data_i,
   input  wire logic       dev_oe_i,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic      [2:0] addr_o,
   output logic      [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       host_oe = 1'b0;
   logic [7:0] host_d  = 8'h00;
   logic [7:0] last_q  = 8'hA5;
   logic [7:0] rd_byte;
   logic       rd_oe;
   event       rd_ev;
   // A released bus never keeps the last byte, so it shows a pattern that flips every cycle.
   assign bus_o = dev_oe_i ? dev_data_i : (host_oe ? host_d : ~last_q);
   always @(posedge sys_clk_i) last_q <= bus_o;
   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 3'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // -------------------------------------------------------------------
   // Bus cycles
   // -------------------------------------------------------------------
   // Levels are held for several cycles because the block sees the pins through two flops.
   task automatic bus_write(input logic sel_n, input logic [2:0] a, input logic [7:0] d);
      cs_n_o = sel_n;
      addr_o = a;
      host_d = d;
      host_oe = 1'b1;
      tick(1);
      wr_n_o = 1'b0;
      tick(5);
      wr_n_o = 1'b1;
      tick(4);
      cs_n_o = 1'b1;
      host_oe = 1'b0;
      tick(4);
   endtask
   task automatic bus_read(input logic [2:0] a);
      cs_n_o = 1'b0;
      addr_o = a;
      tick(1);
      rd_n_o = 1'b0;
      repeat (6) @(posedge sys_clk_i);
      rd_byte = bus_o;
      rd_oe = dev_oe_i;
      -> rd_ev;
      #1;
      rd_n_o = 1'b1;
      tick(4);
      cs_n_o = 1'b1;
      tick(4);
   endtask
endmodule

//--- tb/uart_pins_tb.sv
// Self-checking testbench of the UART pin block driven by a host bus model.
module uart_pins_tb import uart_pins_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic            sys_clk = 1'b0;
   logic            sys_rst, iso, rx, cts_n, dsr_n, cd_n, ri_n;
   wire logic       cs_n, rd_n, wr_n, data_oe, irq, irq_oe, tx, rx_act, rts_n, dtr_n, tx_stop;
   wire logic [2:0] addr;
   wire logic [7:0] bus, data_o;
   wire logic [7:0] pins = {data_oe, tx, rts_n, dtr_n, irq_oe, tx_stop, irq, rx_act};
   logic      [8:0] exp_q[$];
   logic     [31:0] seed = 32'hD3C201B6;
   logic      [7:0] v;
   logic      [7:0] mcr_tab [5] = '{8'h01, 8'h02, 8'h08, 8'h40, 8'h4B};
   int              err_count = 0;
   int              n_tests = 0;
   initial forever #4 sys_clk = ~sys_clk;
   host_bus_model host (.sys_clk_i(sys_clk), .dev_data_i(data_o), .dev_oe_i(data_oe), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .bus_o(bus));
   uart_pins DUT (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .chip_sel_n_i(cs_n), .read_strobe_n_i(rd_n),
      .write_strobe_n_i(wr_n), .register_select_lines_i(addr), .data_i(bus), .data_o(data_o),
      .data_oe_o(data_oe), .bus_isolate_in_i(iso), .irq_o(irq), .irq_oe_o(irq_oe), .tx_o(tx),
      .rx_i(rx), .rx_active_o(rx_act), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .tx_stop_o(tx_stop),
      .cts_n_i(cts_n), .dsr_n_i(dsr_n), .cd_n_i(cd_n), .ri_n_i(ri_n));
   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pins(input logic [7:0] exp);
      cmp({1'b0, pins}, {1'b0, exp});
   endtask
   // A note with a clear drive flag expects a released bus, whose byte is then meaningless.
   task automatic chk_rd(input logic [8:0] got);
      logic [8:0] e;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF;
      cmp(e[8] ? got : {got[8], 8'h00}, e);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back({1'b1, e});
      host.bus_read(a);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.bus_write(1'b0, a, d);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(host.rd_ev) chk_rd({host.rd_oe, host.rd_byte});
   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      iso = 1'b0;
      {rx, cts_n, dsr_n, cd_n, ri_n} = 5'h0F;
      tick(20);
      chk_pins(8'h70);
      sys_rst = 1'b0;
      rx = 1'b1;
      tick(4);
      chk_pins(8'h70);
      for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
      $display("test reset values done");
      // Read-only and unmapped offsets must swallow writes while scratch keeps its byte.
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         wr(SCRATCH_OFS, v);
         wr(LINE_STATUS_OFS, ~v);
         wr(3'h3, ~v);
         rd(SCRATCH_OFS, v);
         rd(LINE_STATUS_OFS, 8'h00);
         rd(3'h3, 8'h00);
      end
      host.bus_write(1'b1, SCRATCH_OFS, ~v);
      iso = 1'b1;
      tick(3);
      wr(SCRATCH_OFS, rnd());
      exp_q.push_back(9'h000);
      host.bus_read(SCRATCH_OFS);
      iso = 1'b0;
      tick(3);
      rd(SCRATCH_OFS, v);
      $display("test bus access done");
      for (int i = 0; i < 5; i++)
      begin
         v = mcr_tab[i];
         wr(MODEM_CTRL_OFS, v);
         rd(MODEM_CTRL_OFS, v);
         for (int r = 0; r < 2; r++)
         begin
            rx = r[0];
            tick(5);
            chk_pins({1'b0, ~v[6], ~v[1:0], v[3], 2'b00, rx ^ ~v[6]});
            rd(LINE_STATUS_OFS, {7'h00, rx ^ ~v[6]});
         end
      end
      $display("test line modes done");
      wr(MODEM_CTRL_OFS, 8'h02);
      wr(ENH_FEATURE_OFS, 8'hC0);
      wr(IRQ_ENABLE_OFS, 8'hC1);
      rd(IRQ_ENABLE_OFS, 8'hC1);
      rd(ENH_FEATURE_OFS, 8'hC0);
      chk_pins(8'h54);
      cts_n = 1'b0;
      tick(6);
      chk_pins(8'h52);
      rd(MODEM_STATUS_OFS, 8'h11);
      chk_pins(8'h50);
      {dsr_n, cd_n, ri_n} = 3'h0;
      tick(6);
      chk_pins(8'h50);
      rd(MODEM_STATUS_OFS, 8'hFE);
      rd(MODEM_STATUS_OFS, 8'hF0);
      $display("test modem lines done");
      wr(MODEM_CTRL_OFS, 8'h4B);
      wr(SCRATCH_OFS, 8'h3C);
      {cts_n, dsr_n, cd_n, ri_n} = 4'hF;
      tick(6);
      chk_pins(8'h0F);
      sys_rst = 1'b1;
      tick(RST_MIN_CYC);
      chk_pins(8'h70);
      sys_rst = 1'b0;
      tick(4);
      rd(MODEM_CTRL_OFS, 8'h00);
      rd(SCRATCH_OFS, 8'h00);
      $display("test mid-run reset done");
      final_report();
   end
   initial
   begin
      #100us;
      err_count++;
      final_report();
   end
endmodule
